// ===== rtl/dce_pkg.sv
/*
 * Shared constants, register map and carrier types of the checksum engine.
 * Assumes a 32-bit AXI4-Lite register bus, 8-bit registers in the low byte
 * of each word, and a packet buffer read port with one cycle of latency.
 */
package dce_pkg;

    localparam int ADDR_W = 8;
    localparam int PTR_W  = 13;
    localparam int SUM_W  = 16;
    localparam int NPTR   = 5;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_EVENT_ENABLE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MAIN_CTRL    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SUM_LO       = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_SUM_HI       = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PTR_BASE     = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_PTR_STEP     = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PTR_HI_ADD   = 8'h04;

    // pointer slots: start, end, destination, rx end, rx start
    localparam int PTR_START   = 0;
    localparam int PTR_END     = 1;
    localparam int PTR_DEST    = 2;
    localparam int PTR_RXEND   = 3;
    localparam int PTR_RXSTART = 4;

    // bit positions
    localparam int BIT_GLOBAL_IRQ_EN = 7;
    localparam int BIT_DONE_EN       = 5;
    localparam int BIT_DONE_FLAG     = 5;
    localparam int BIT_GO_BUSY       = 5;
    localparam int BIT_SUM_MODE      = 4;

    // reset values
    localparam logic [7:0]       RST_BYTE = 8'h00;
    localparam logic [PTR_W-1:0] RST_PTR  = 13'h0000;
    localparam logic [SUM_W-1:0] RST_SUM  = 16'h0000;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_RUN   = 2'b01,
        S_DRAIN = 2'b10
    } dce_state_t;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } dce_axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } dce_axil_rsp_t;

    typedef struct packed {
        logic             rd_en;
        logic [PTR_W-1:0] rd_addr;
    } dce_mem_req_t;

endpackage : dce_pkg

// ===== rtl/dce_sum_acc.sv
/*
 * Ones-complement byte-pair accumulator of the checksum engine.
 * Assumes bytes arrive in address order with a last marker on the final
 * byte, and that clear is given before the first byte of a job.
 */
`timescale 1ns/10ps
`default_nettype none
module dce_sum_acc #(
    parameter int SUM_W = 16
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             srst,
    // byte stream
    input  wire logic             clear,
    input  wire logic             byte_vld,
    input  wire logic [7:0]       byte_data,
    input  wire logic             byte_last,
    // result
    output var  logic [SUM_W-1:0] sum,
    output var  logic             sum_done
);
    import dce_pkg::*;

    generate
        if (SUM_W != 16)
        begin : g_chk
            $error("dce_sum_acc serves only 16-bit sums");
        end
    endgenerate

    logic [7:0]       hi_ff;
    logic             phase_ff;
    logic [SUM_W-1:0] sum_ff;
    logic             done_ff;

    // odd tail pads a zero low half
    wire [SUM_W-1:0] word    = phase_ff ? {hi_ff, byte_data}
                                        : {byte_data, 8'h00};
    wire             add_now = byte_vld & (phase_ff | byte_last);
    wire [SUM_W:0]   raw     = {1'b0, sum_ff} + {1'b0, word};
    // fold cannot carry again: max raw is 1FFFE
    wire [SUM_W-1:0] folded  = raw[SUM_W-1:0]
                             + {{(SUM_W-1){1'b0}}, raw[SUM_W]};

    always_ff @(posedge sys_clk)
    begin
        if (srst || clear)
        begin
            hi_ff    <= RST_BYTE;
            phase_ff <= 1'b0;
            sum_ff   <= RST_SUM;
            done_ff  <= 1'b0;
        end
        else
        begin
            if (byte_vld)
                hi_ff <= byte_data;
            if (byte_vld)
                phase_ff <= ~phase_ff & ~byte_last;
            if (add_now)
                sum_ff <= folded;
            done_ff <= byte_vld & byte_last;
        end
    end

    assign sum      = sum_ff;
    assign sum_done = done_ff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    pair_word_a: assert property (
        byte_vld && phase_ff && !clear |=>
            sum == ($past(raw[15:0]) + {15'h0, $past(raw[16])})
            && $past(word) == {$past(hi_ff), $past(byte_data)})
        else $error("byte pair not summed high first");
    odd_pad_a: assert property (
        byte_vld && !phase_ff && byte_last && !clear |->
            word[7:0] == 8'h00 && word[15:8] == byte_data)
        else $error("odd tail not padded with zero");
    fold_carry_a: assert property (
        add_now && !clear && raw[16] |=> sum == $past(raw[15:0]) + 16'h0001)
        else $error("end-around carry lost");
    clear_sum_a: assert property (
        clear |=> sum == RST_SUM && !sum_done)
        else $error("sum not cleared");

endmodule : dce_sum_acc
`default_nettype wire

// ===== rtl/dce_checksum_engine.sv
/*
 * Checksum mode of the buffer mover: AXI4-Lite register file, source walk
 * over the packet buffer with receive-area wrap, completion and interrupt.
 * Assumes the buffer read port returns data one cycle after rd_en, and
 * that software keeps pointers and mode still while a job runs.
 */
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dce_checksum_engine (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    // register bus
    input  wire dce_pkg::dce_axil_req_t axil_req,
    output var  dce_pkg::dce_axil_rsp_t axil_rsp,
    // packet buffer read port
    output var  dce_pkg::dce_mem_req_t  mem_req,
    input  wire logic [7:0]            mem_rd_data,
    // interrupt, low while asserted
    output var  logic                  irq_n
);
    import dce_pkg::*;

    // bus state
    logic              awready_ff, wready_ff, aw_full_ff, w_full_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [7:0]        wdata_ff;
    logic              wlane_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              arready_ff, rvalid_ff;
    logic [31:0]       rdata_ff;
    logic [1:0]        rresp_ff;
    // registers
    logic [7:0]        event_enable_ff;
    logic              done_flag_ff;
    logic [7:0]        main_ctrl_ff;
    logic [PTR_W-1:0]  ptr_ff [NPTR];
    logic [SUM_W-1:0]  sum_result_ff;
    // engine
    dce_state_t        state_ff, nxt_state;
    logic [PTR_W-1:0]  src_ff;
    logic              rd_en_ff, byte_vld_ff, byte_last_ff;
    logic              irq_n_ff;
    logic [SUM_W-1:0]  acc_sum;
    logic              acc_done;

    // write channel: address and data held independently
    wire aw_take     = axil_req.awvalid & awready_ff;
    wire w_take      = axil_req.wvalid & wready_ff;
    wire wr_fire     = aw_full_ff & w_full_ff & ~bvalid_ff;
    wire nxt_aw_full = (aw_full_ff | aw_take) & ~wr_fire;
    wire nxt_w_full  = (w_full_ff | w_take) & ~wr_fire;
    wire nxt_bvalid  = wr_fire | (bvalid_ff & ~axil_req.bready);
    wire wr_strobe   = wr_fire & wlane_ff;
    wire ar_take     = axil_req.arvalid & arready_ff;
    wire nxt_rvalid  = ar_take | (rvalid_ff & ~axil_req.rready);

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic hit;
        hit = (a == OFS_EVENT_ENABLE) || (a == OFS_EVENT_FLAGS)
           || (a == OFS_MAIN_CTRL) || (a == OFS_SUM_LO)
           || (a == OFS_SUM_HI);
        for (int i = 0; i < NPTR; i++)
        begin
            if (a == OFS_PTR_BASE + ADDR_W'(i) * OFS_PTR_STEP ||
                a == OFS_PTR_BASE + ADDR_W'(i) * OFS_PTR_STEP
                     + OFS_PTR_HI_ADD)
                hit = 1'b1;
        end
        return hit;
    endfunction : is_mapped

    wire wr_enable_reg = wr_strobe & (awaddr_ff == OFS_EVENT_ENABLE);
    wire wr_flags_reg  = wr_strobe & (awaddr_ff == OFS_EVENT_FLAGS);
    wire wr_ctrl_reg   = wr_strobe & (awaddr_ff == OFS_MAIN_CTRL);

    // engine decode
    wire go_bit    = main_ctrl_ff[BIT_GO_BUSY];
    wire busy      = (state_ff != S_IDLE);
    wire start_job = ~busy & go_bit & main_ctrl_ff[BIT_SUM_MODE];
    wire cancel    = busy & ~go_bit;
    wire at_end    = (src_ff == ptr_ff[PTR_END]);
    wire at_rx_end = (src_ff == ptr_ff[PTR_RXEND]);
    wire finish    = (state_ff == S_DRAIN) & acc_done & go_bit;
    // wrap at the receive area end, else linear
    wire [PTR_W-1:0] src_step = at_rx_end ? ptr_ff[PTR_RXSTART]
                                          : src_ff + 13'h0001;

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            S_IDLE:
                if (start_job)
                    nxt_state = S_RUN;
            S_RUN:
                if (cancel)
                    nxt_state = S_IDLE;
                else if (at_end)
                    nxt_state = S_DRAIN;
            S_DRAIN:
                if (cancel || finish)
                    nxt_state = S_IDLE;
            default:
                nxt_state = S_IDLE;
        endcase
    end

    // set beats clear: a finishing job never loses its flag
    wire nxt_done = (done_flag_ff
                     & ~(wr_flags_reg & ~wdata_ff[BIT_DONE_FLAG]))
                  | finish | cancel;

    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (axil_req.araddr)
            OFS_EVENT_ENABLE: rd_mux[7:0] = event_enable_ff;
            OFS_EVENT_FLAGS:  rd_mux[BIT_DONE_FLAG] = done_flag_ff;
            OFS_MAIN_CTRL:    rd_mux[7:0] = main_ctrl_ff;
            OFS_SUM_LO:       rd_mux[7:0] = sum_result_ff[7:0];
            OFS_SUM_HI:       rd_mux[7:0] = sum_result_ff[15:8];
            default:
                for (int i = 0; i < NPTR; i++)
                begin
                    if (axil_req.araddr
                        == OFS_PTR_BASE + ADDR_W'(i) * OFS_PTR_STEP)
                        rd_mux[7:0] = ptr_ff[i][7:0];
                    if (axil_req.araddr == OFS_PTR_BASE
                        + ADDR_W'(i) * OFS_PTR_STEP + OFS_PTR_HI_ADD)
                        rd_mux[PTR_W-9:0] = ptr_ff[i][PTR_W-1:8];
                end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
        end
        else
        begin
            aw_full_ff <= nxt_aw_full;
            w_full_ff  <= nxt_w_full;
            awready_ff <= ~nxt_aw_full;
            wready_ff  <= ~nxt_w_full;
            bvalid_ff  <= nxt_bvalid;
            arready_ff <= ~nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
        end
    end

    // payload flops need no reset: qualified by the flags above
    always_ff @(posedge sys_clk)
    begin
        if (aw_take)
            awaddr_ff <= axil_req.awaddr;
        if (w_take)
            wdata_ff <= axil_req.wdata[7:0];
        if (w_take)
            wlane_ff <= axil_req.wstrb[0];
        if (wr_fire)
            bresp_ff <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
        if (ar_take)
            rdata_ff <= rd_mux;
        if (ar_take)
            rresp_ff <= is_mapped(axil_req.araddr) ? RESP_OKAY
                                                   : RESP_SLVERR;
    end

    // pointer pairs: low byte and bits 12:8; the engine never writes them
    genvar gi;
    generate
        for (gi = 0; gi < NPTR; gi++)
        begin : g_ptr
            localparam logic [ADDR_W-1:0] LO =
                OFS_PTR_BASE + ADDR_W'(gi) * OFS_PTR_STEP;
            wire wr_lo = wr_strobe & (awaddr_ff == LO);
            wire wr_hi = wr_strobe & (awaddr_ff == LO + OFS_PTR_HI_ADD);
            always_ff @(posedge sys_clk)
            begin
                if (srst)
                    ptr_ff[gi] <= RST_PTR;
                else if (wr_lo)
                    ptr_ff[gi][7:0] <= wdata_ff;
                else if (wr_hi)
                    ptr_ff[gi][PTR_W-1:8] <= wdata_ff[PTR_W-9:0];
            end
        end
    endgenerate

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            event_enable_ff <= RST_BYTE;
            done_flag_ff    <= 1'b0;
            main_ctrl_ff    <= RST_BYTE;
            sum_result_ff   <= RST_SUM;
            irq_n_ff        <= 1'b1;
        end
        else
        begin
            if (wr_enable_reg)
                event_enable_ff <= wdata_ff;
            done_flag_ff <= nxt_done;
            if (wr_ctrl_reg)
                main_ctrl_ff <= wdata_ff;
            else if (finish)
                main_ctrl_ff[BIT_GO_BUSY] <= 1'b0;
            if (finish)
                sum_result_ff <= ~acc_sum;
            irq_n_ff <= ~(done_flag_ff & event_enable_ff[BIT_DONE_EN]
                          & event_enable_ff[BIT_GLOBAL_IRQ_EN]);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_ff     <= S_IDLE;
            src_ff       <= RST_PTR;
            rd_en_ff     <= 1'b0;
            byte_vld_ff  <= 1'b0;
            byte_last_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (start_job)
                src_ff <= ptr_ff[PTR_START];
            else if (state_ff == S_RUN)
                src_ff <= src_step;
            rd_en_ff     <= (nxt_state == S_RUN);
            byte_vld_ff  <= rd_en_ff & ~cancel;
            byte_last_ff <= rd_en_ff & at_end;
        end
    end

    dce_sum_acc #(
        .SUM_W     (SUM_W)
    ) u_acc (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .clear     (start_job),
        .byte_vld  (byte_vld_ff),
        .byte_data (mem_rd_data),
        .byte_last (byte_last_ff),
        .sum       (acc_sum),
        .sum_done  (acc_done)
    );

    assign axil_rsp = '{awready: awready_ff, wready: wready_ff,
                        bvalid: bvalid_ff, bresp: bresp_ff,
                        arready: arready_ff, rvalid: rvalid_ff,
                        rdata: rdata_ff, rresp: rresp_ff};
    // read only: the engine has no buffer write port at all
    assign mem_req  = '{rd_en: rd_en_ff, rd_addr: src_ff};
    assign irq_n    = irq_n_ff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence job_start_s;
        start_job ##1 (state_ff == S_RUN);
    endsequence
    start_load_a: assert property (
        job_start_s |-> src_ff == $past(ptr_ff[PTR_START]) && rd_en_ff)
        else $error("source pointer not loaded at start");
    byte_rate_a: assert property (
        state_ff == S_RUN && !cancel && !at_end && !at_rx_end
        |=> src_ff == $past(src_ff) + 13'h0001 && rd_en_ff)
        else $error("source did not advance one byte per cycle");
    rx_wrap_a: assert property (
        state_ff == S_RUN && !cancel && at_rx_end && !at_end
        |=> src_ff == $past(ptr_ff[PTR_RXSTART]))
        else $error("receive area wrap missed");
    end_stop_a: assert property (
        state_ff == S_RUN && !cancel && at_end
        |=> state_ff == S_DRAIN && !rd_en_ff && byte_last_ff ##1 !byte_last_ff)
        else $error("walk did not stop at end pointer");
    finish_flags_a: assert property (
        finish && !wr_ctrl_reg |=> !go_bit && done_flag_ff && !busy)
        else $error("completion did not clear go and set done");
    result_split_a: assert property (
        finish |=> sum_result_ff[15:8] == ~$past(acc_sum[15:8])
                   && sum_result_ff[7:0] == ~$past(acc_sum[7:0]))
        else $error("result bytes misplaced");
    cancel_keep_a: assert property (
        cancel |=> !busy && done_flag_ff && $stable(sum_result_ff))
        else $error("cancel changed result or lost done");
    ptr_still_a: assert property (
        busy && !wr_strobe |=> $stable(ptr_ff[PTR_START])
            && $stable(ptr_ff[PTR_END]) && $stable(ptr_ff[PTR_DEST]))
        else $error("pointer changed during job");
    irq_level_a: assert property (
        done_flag_ff && event_enable_ff[BIT_DONE_EN]
        && event_enable_ff[BIT_GLOBAL_IRQ_EN] |=> !irq_n)
        else $error("interrupt not asserted");
    done_sticky_a: assert property (
        done_flag_ff && !wr_flags_reg |=> done_flag_ff)
        else $error("done flag dropped without clear");

endmodule : dce_checksum_engine
`default_nettype wire

// ===== testbench/dce_buf_model.sv
/*
 * Packet buffer read port model: 8-Kbyte byte array, one cycle latency.
 * Assumes the engine changes mem_req only right after a rising edge.
 */
`timescale 1ns/10ps
`default_nettype none
module dce_buf_model (
    // clock
    input  wire logic                  sys_clk,
    // read port
    input  wire dce_pkg::dce_mem_req_t mem_req,
    output var  logic [7:0]            mem_rd_data
);
    import dce_pkg::*;
    logic [7:0] mem [0:8191];
    initial
    begin
        for (int i = 0; i < 8192; i++)
            mem[i] = 8'(i * 37 + 11);
        mem[0] = 8'h89;
        mem[1] = 8'hAB;
        mem[2] = 8'hCD;
        mem_rd_data = 8'h5A;
    end
    // no write port: the engine cannot write the buffer, only the bench writes the array directly
    always @(posedge sys_clk)
    begin
        if (mem_req.rd_en)
            mem_rd_data <= mem[mem_req.rd_addr];
        else
            mem_rd_data <= ~mem_rd_data; // idle data is never held
    end
endmodule : dce_buf_model
`default_nettype wire

// ===== testbench/tb.sv
/*
 * Self-checking bench of the checksum engine over AXI4-Lite.
 * Assumes the buffer model's array holds the bytes that are summed.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import dce_pkg::*;
    logic          sys_clk;
    logic          srst;
    dce_axil_req_t req;
    dce_axil_rsp_t rsp;
    dce_mem_req_t  mem_req;
    logic [7:0]    mem_rd_data;
    logic          irq_n;
    int            mismatches;
    int            checked;
    int            nrd;
    int            cyc;
    int            first;
    int            last;
    int            fa;

    dce_checksum_engine u_dce_checksum_engine (.sys_clk(sys_clk),
        .srst(srst), .axil_req(req), .axil_rsp(rsp), .mem_req(mem_req),
        .mem_rd_data(mem_rd_data), .irq_n(irq_n));
    dce_buf_model u_dce_buf_model (.sys_clk(sys_clk), .mem_req(mem_req),
        .mem_rd_data(mem_rd_data));

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // read strobe watch: count, span and first address
    always @(posedge sys_clk)
    begin
        cyc++;
        if (mem_req.rd_en === 1'b1)
        begin
            if (nrd == 0)
            begin
                first = cyc;
                fa = int'(mem_req.rd_addr);
            end
            nrd++;
            last = cyc;
        end
    end

    task automatic complete_run();
        begin
            $display("checked=%0d mismatches=%0d", checked, mismatches);
            if (mismatches == 0 && checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask : complete_run

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        begin
            checked++;
            if (g !== x)
            begin
                $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
                mismatches++;
            end
        end
    endtask : chk

    task automatic tmo(input int n);
        begin
            if (n >= 60)
            begin
                $display("CHECK FAILED t=%0t wait ran out", $time);
                mismatches++;
                complete_run();
            end
        end
    endtask : tmo

    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        int n;
        begin
            @(posedge sys_clk);
            req.awvalid <= 1'b1;
            req.awaddr  <= a;
            req.wvalid  <= 1'b1;
            req.wdata   <= v;
            req.bready  <= 1'b1;
            n = 0;
            do
            begin
                @(posedge sys_clk);
                n++;
                if (rsp.awready === 1'b1)
                    req.awvalid <= 1'b0;
                if (rsp.wready === 1'b1)
                    req.wvalid <= 1'b0;
            end while (rsp.bvalid !== 1'b1 && n < 60);
            req.bready <= 1'b0;
            chk(32'(rsp.bresp), 32'(er));
            tmo(n);
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      input logic [1:0] er);
        int n;
        begin
            @(posedge sys_clk);
            req.arvalid <= 1'b1;
            req.araddr  <= a;
            req.rready  <= 1'b1;
            n = 0;
            do
            begin
                @(posedge sys_clk);
                n++;
                if (rsp.arready === 1'b1)
                    req.arvalid <= 1'b0;
            end while (rsp.rvalid !== 1'b1 && n < 60);
            req.rready <= 1'b0;
            d = rsp.rdata;
            chk(32'(rsp.rresp), 32'(er));
            tmo(n);
        end
    endtask : rd

    task automatic setp(input int slot, input int v);
        logic [7:0] a;
        begin
            a = 8'(OFS_PTR_BASE + slot * OFS_PTR_STEP);
            wr(a, 32'(v & 255), RESP_OKAY);
            wr(8'(a + OFS_PTR_HI_ADD), 32'(v >> 8), RESP_OKAY);
        end
    endtask : setp

    // walk with receive-area wrap, then fold pairs
    function automatic logic [15:0] csum(input int s, input int e,
                                         input int rs, input int re);
        logic [7:0]  q[$];
        logic [16:0] acc;
        int          p;
        p = s;
        forever
        begin
            q.push_back(u_dce_buf_model.mem[p]);
            if (p == e)
                break;
            p = (p == re) ? rs : (p + 1) % 8192;
        end
        if (q.size() % 2 == 1)
            q.push_back(8'h00);
        acc = '0;
        for (int i = 0; i < q.size(); i += 2)
        begin
            acc = acc + {1'b0, q[i], q[i + 1]};
            acc = 17'(acc[15:0]) + 17'(acc[16]);
        end
        return ~acc[15:0];
    endfunction : csum

    task automatic arm(input int s, input int e, input int rs, input int re,
                       input logic ien);
        begin
            setp(PTR_START, s);
            setp(PTR_END, e);
            setp(PTR_RXSTART, rs);
            setp(PTR_RXEND, re);
            wr(OFS_EVENT_FLAGS, 32'h0, RESP_OKAY);
            wr(OFS_EVENT_ENABLE, {24'h0, ien, 1'b0, ien, 5'h0}, RESP_OKAY);
            nrd = 0;
            wr(OFS_MAIN_CTRL, 32'h30, RESP_OKAY);
        end
    endtask : arm

    task automatic job(input int s, input int e, input int rs, input int re,
                       input logic ien, input int nb, input logic [15:0] x);
        logic [31:0] d;
        int          n;
        begin
            arm(s, e, rs, re, ien);
            n = 0;
            d = 32'h20;
            while (d[BIT_GO_BUSY] !== 1'b0 && n < 60)
            begin
                rd(OFS_MAIN_CTRL, d, RESP_OKAY);
                n++;
            end
            tmo(n);
            chk(nrd, nb);
            chk(last - first + 1, nb);
            chk(fa, s);
            rd(OFS_SUM_LO, d, RESP_OKAY);
            chk(d, 32'(x[7:0]));
            rd(OFS_SUM_HI, d, RESP_OKAY);
            chk(d, 32'(x[15:8]));
            rd(OFS_EVENT_FLAGS, d, RESP_OKAY);
            chk(d, 32'h20);
            rd(OFS_PTR_BASE, d, RESP_OKAY);
            chk(d, 32'(s & 255));
            chk(32'(irq_n), 32'(!ien));
        end
    endtask : job

    task automatic s_regs();
        logic [31:0] d;
        logic        m;
        begin
            for (int a = 0; a < 8'h4C; a += 4)
            begin
                m = (a <= 8'h10) || (a >= 8'h20 && a <= 8'h44);
                rd(8'(a), d, m ? RESP_OKAY : RESP_SLVERR);
                chk(d, 32'h0);
            end
            wr(8'h18, 32'hFF, RESP_SLVERR);
            wr(8'(OFS_PTR_BASE + OFS_PTR_HI_ADD), 32'hFF, RESP_OKAY);
            rd(8'(OFS_PTR_BASE + OFS_PTR_HI_ADD), d, RESP_OKAY);
            chk(d, 32'h1F);
            // lane 0 strobe low: write must be ignored
            req.wstrb <= 4'h0;
            wr(OFS_EVENT_ENABLE, 32'hFF, RESP_OKAY);
            req.wstrb <= 4'hF;
            rd(OFS_EVENT_ENABLE, d, RESP_OKAY);
            chk(d, 32'h0);
        end
    endtask : s_regs

    task automatic s_nomode();
        logic [31:0] d;
        begin
            nrd = 0;
            wr(OFS_MAIN_CTRL, 32'h20, RESP_OKAY);
            repeat (10) @(posedge sys_clk);
            chk(nrd, 0);
            rd(OFS_MAIN_CTRL, d, RESP_OKAY);
            chk(d, 32'h20);
            wr(OFS_MAIN_CTRL, 32'h0, RESP_OKAY);
        end
    endtask : s_nomode

    task automatic s_flagclr();
        logic [31:0] d;
        begin
            wr(OFS_EVENT_FLAGS, 32'h0, RESP_OKAY);
            rd(OFS_EVENT_FLAGS, d, RESP_OKAY);
            chk(d, 32'h0);
            chk(32'(irq_n), 32'h1);
        end
    endtask : s_flagclr

    // received packet has its sum bytes 12..13 zeroed again before the job
    task automatic s_verify();
        logic [15:0] x;
        begin
            u_dce_buf_model.mem[12] = 8'h00;
            u_dce_buf_model.mem[13] = 8'h00;
            x = csum(10, 17, 0, 8191);
            u_dce_buf_model.mem[12] = x[15:8];
            u_dce_buf_model.mem[13] = x[7:0];
            x = {u_dce_buf_model.mem[12], u_dce_buf_model.mem[13]};
            u_dce_buf_model.mem[12] = 8'h00;
            u_dce_buf_model.mem[13] = 8'h00;
            job(10, 17, 0, 8191, 1'b0, 8, x);
        end
    endtask : s_verify

    task automatic s_cancel();
        logic [31:0] d;
        logic [31:0] lo;
        int          n0;
        begin
            rd(OFS_SUM_LO, lo, RESP_OKAY);
            arm(0, 8000, 0, 8191, 1'b0);
            repeat (20) @(posedge sys_clk);
            wr(OFS_MAIN_CTRL, 32'h10, RESP_OKAY);
            // the strobe watch counts the cancel edge in this same step
            @(posedge sys_clk);
            n0 = nrd;
            repeat (5) @(posedge sys_clk);
            chk(nrd, n0);
            rd(OFS_EVENT_FLAGS, d, RESP_OKAY);
            chk(d, 32'h20);
            rd(OFS_SUM_LO, d, RESP_OKAY);
            chk(d, lo);
            rd(8'(OFS_PTR_BASE + OFS_PTR_STEP), d, RESP_OKAY);
            chk(d, 32'h40);
        end
    endtask : s_cancel

    initial
    begin
        req = '0;
        req.wstrb = 4'hF;
        srst = 1'b1;
        mismatches = 0;
        checked = 0;
        nrd = 0;
        cyc = 0;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        s_regs();
        s_nomode();
        job(0, 2, 0, 8191, 1'b1, 3, 16'hA953);
        s_flagclr();
        job(10, 17, 0, 8191, 1'b0, 8, csum(10, 17, 0, 8191));
        s_verify();
        job(100, 97, 96, 103, 1'b0, 6, csum(100, 97, 96, 103));
        job(50, 50, 0, 8191, 1'b1, 1, csum(50, 50, 0, 8191));
        s_cancel();
        complete_run();
    end
endmodule : tb
`default_nettype wire
